// File: rtl/branch_unit.sv
// branch, table jump and if-then control for the core
// Function
// RL1: call writes next instruction address to return link before fetch redirect
// RL2: register jump with target bit zero clear raises illegal use fault
// RL3: valid register jump target has bit zero forced to zero
// RL4: conditional immediate jump outside block reaches plus or minus one megabyte
// RL5: other immediate jumps and calls reach plus or minus sixteen megabytes
// RL6: jump, call, compare, if-then and table jumps leave flags unchanged
// RL7: software places program counter writers outside a block or last
// RL8: software never names program counter as register call target
// RL9: compare jumps branch on operand zero or nonzero, flags untouched
// RL10: compare jumps take low registers only, forward 4 to 130 bytes
// RL11: software keeps compare jumps out of if-then blocks
// RL12: if-then prefix makes one to four following instructions conditional
// RL13: later slots use base condition for then, its inverse for else
// RL14: with always condition software gives no else slots
// RL15: debug stop inside a block executes even when condition fails
// RL16: exceptions may interrupt a block; saved state resumes it correctly
// RL17: software puts no prefix, compare jump or mask change in blocks
// RL18: software enters block middles only by exception return
// RL19: software keeps conditional instructions inside blocks with matching conditions
// RL20: table jump doubles unsigned entry, branches forward from next instruction
// RL21: halfword table jump shifts index left by one
// RL22: program counter base means table starts right after the instruction
// RL23: if-then state holds base condition and slots, advances, clears at end
`timescale 1ns/1ps
`include "branch_cfg.svh"

module branch_unit
  import branch_pkg::*;
(
  // clock and reset
  input  wire logic        sys_clk,
  input  wire logic        rst_n,
  input  wire logic        clk_en,
  // instruction stream
  input  wire logic        instr_valid,
  input  instr_s           instr,
  output logic             instr_ready,
  input  wire logic [3:0]  flags_nzcv,
  // results
  output branch_out_s      result_q,
  output logic             it_active,
  // exception save and return
  input  wire logic        exc_entry,
  input  wire logic        exc_return,
  input  wire logic [7:0]  exc_it_restore,
  output logic [7:0]       exc_it_save,
  // table read port
  output logic             tbl_valid,
  output tbl_req_s         tbl_q,
  input  wire logic        tbl_ack,
  input  wire logic [15:0] tbl_data
);

  // -----------------------------------------------------------------
  // decode helpers
  // -----------------------------------------------------------------
  function automatic logic cond_pass(input logic [3:0] c, input logic [3:0] f);
    logic r;
    r = 1'b1;
    case (c[3:1])
      3'h0:    r = f[2];
      3'h1:    r = f[1];
      3'h2:    r = f[3];
      3'h3:    r = f[0];
      3'h4:    r = f[1] & ~f[2];
      3'h5:    r = (f[3] == f[0]);
      3'h6:    r = (f[3] == f[0]) & ~f[2];
      default: r = 1'b1;
    endcase
    // the always group has no inverse
    cond_pass = (c[0] && c[3:1] != `COND_ALWAYS_HI) ? ~r : r;
  endfunction

  function automatic logic [31:0] limit_disp(input logic [31:0] d, input logic wide);
    if (wide) begin
      limit_disp = {{(31 - `WIDE_DISP_MSB){d[`WIDE_DISP_MSB]}}, d[`WIDE_DISP_MSB:0]};
    end else begin
      limit_disp = {{(31 - `NARROW_DISP_MSB){d[`NARROW_DISP_MSB]}}, d[`NARROW_DISP_MSB:0]};
    end
  endfunction

  // -----------------------------------------------------------------
  // if-then state
  // -----------------------------------------------------------------
  logic        it_load;
  logic        it_adv;
  logic [7:0]  it_state;
  logic [3:0]  slot_cond;

  it_state_unit u_it (
    .sys_clk     (sys_clk),
    .rst_n       (rst_n),
    .clk_en      (clk_en),
    .load        (it_load),
    .load_val    ({instr.cond, instr.it_mask}),
    .advance     (it_adv),
    .clear       (exc_entry),
    .restore     (exc_return),
    .restore_val (exc_it_restore),
    .state_q     (it_state),
    .active      (it_active),
    .slot_cond   (slot_cond)
  );

  // exception entry stacks this with the status word
  assign exc_it_save = it_state;                                  // RL16

  // -----------------------------------------------------------------
  // control
  // -----------------------------------------------------------------
  unit_state_e state_q;
  unit_state_e state_d;
  branch_out_s result_d;
  tbl_req_s    tbl_d;
  logic [31:0] base_q;
  logic [31:0] base_d;
  logic        take;
  logic        slot_ok;
  logic [31:0] pc_ahead;
  logic [31:0] next_addr;
  logic [31:0] tbl_off;

  // exceptions own the cycle, so no instruction is taken alongside
  assign instr_ready = (state_q == ST_IDLE) && !exc_entry && !exc_return;
  assign take        = instr_valid && instr_ready;
  assign tbl_valid   = (state_q == ST_TABLE);
  assign pc_ahead    = instr.pc + `PC_AHEAD;
  assign next_addr   = instr.pc + (instr.wide ? `INSTR_WIDE_LEN : `INSTR_NARROW_LEN);
  // flags are only read, never written by this unit
  assign slot_ok     = !it_active || cond_pass(slot_cond, flags_nzcv)
                       || (instr.op == OP_DBG_STOP);              // RL15 RL6
  assign tbl_off     = tbl_q.half ? {16'h0000, tbl_data} : {24'h000000, tbl_data[7:0]};

  always_comb begin
    state_d  = state_q;
    base_d   = base_q;
    tbl_d    = tbl_q;
    result_d = '0;
    it_load  = 1'b0;
    it_adv   = 1'b0;
    case (state_q)
      ST_IDLE: begin
        if (take && clk_en) begin
          it_adv           = it_active && (instr.op != OP_IF_THEN); // RL23
          result_d.cond_ok = slot_ok;                             // RL12 RL13
          if (slot_ok) begin
            case (instr.op)
              OP_JUMP: begin
                result_d.redirect = 1'b1;
                result_d.target   = pc_ahead + limit_disp(instr.disp, 1'b1); // RL5
              end
              OP_JUMP_CC: begin
                // inside a block the slot condition already decided
                result_d.redirect = it_active || cond_pass(instr.cond, flags_nzcv);
                result_d.target   = pc_ahead + limit_disp(instr.disp, it_active); // RL4 RL5
              end
              OP_CALL: begin
                result_d.link_we  = 1'b1;                         // RL1
                result_d.link     = next_addr;                    // RL1
                result_d.redirect = 1'b1;
                result_d.target   = pc_ahead + limit_disp(instr.disp, 1'b1); // RL5
              end
              OP_JUMP_REG, OP_CALL_REG: begin
                if (!instr.rm_val[0]) begin
                  result_d.fault = 1'b1;                          // RL2
                end else begin
                  result_d.link_we  = (instr.op == OP_CALL_REG);  // RL1
                  result_d.link     = next_addr;                  // RL1
                  result_d.redirect = 1'b1;
                  result_d.target   = {instr.rm_val[31:1], 1'b0}; // RL3
                end
              end
              OP_CMP_ZERO, OP_CMP_NZ: begin
                // a high register operand is not a legal encoding
                if (instr.opnd_idx > `LOW_REG_MAX) begin
                  result_d.fault = 1'b1;                          // RL10
                end else begin
                  result_d.redirect = (instr.op == OP_CMP_ZERO) ==
                                      (instr.opnd_val == 32'h0000_0000); // RL9
                  result_d.target   = pc_ahead + {25'h0000000, instr.disp[6:1], 1'b0}; // RL10
                end
              end
              OP_IF_THEN: begin
                it_load = 1'b1;                                   // RL12
              end
              OP_TBL_BYTE, OP_TBL_HALF: begin
                tbl_d.half = (instr.op == OP_TBL_HALF);
                tbl_d.addr = (instr.rn_is_pc ? pc_ahead : instr.rn_val) // RL22
                           + (tbl_d.half ? {instr.rm_val[30:0], 1'b0}   // RL21
                                         : instr.rm_val);
                base_d  = pc_ahead;                               // RL20
                state_d = ST_TABLE;
              end
              default: begin
              end
            endcase
          end
        end
      end
      ST_TABLE: begin
        if (tbl_ack && clk_en) begin
          result_d.redirect = 1'b1;
          result_d.cond_ok  = 1'b1;
          result_d.target   = base_q + {tbl_off[30:0], 1'b0};      // RL20
          state_d           = ST_IDLE;
        end
      end
      default: begin
        state_d = ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      state_q  <= ST_IDLE;
      base_q   <= 32'h0000_0000;
      tbl_q    <= '0;
      result_q <= '0;
    end else if (clk_en) begin
      state_q  <= state_d;
      base_q   <= base_d;
      tbl_q    <= tbl_d;
      result_q <= result_d;
    end
  end

endmodule

// File: pkg/branch_cfg.svh
// constants for the branch and if-then unit
`ifndef BRANCH_CFG_SVH
`define BRANCH_CFG_SVH

// -----------------------------------------------------------------
// addresses and lengths
// -----------------------------------------------------------------
`define PC_AHEAD          32'h0000_0004
`define INSTR_WIDE_LEN    32'h0000_0004
`define INSTR_NARROW_LEN  32'h0000_0002

// -----------------------------------------------------------------
// displacement limits (sign bit positions)
// -----------------------------------------------------------------
`define WIDE_DISP_MSB     24
`define NARROW_DISP_MSB   20

// -----------------------------------------------------------------
// conditions, registers and reset values
// -----------------------------------------------------------------
`define COND_ALWAYS_HI    3'h7
`define LOW_REG_MAX       4'h7
`define IT_STATE_RESET    8'h00
`define IT_SLOT_NONE      3'h0

`endif

// File: pkg/branch_pkg.sv
// types shared by the branch and if-then unit
package branch_pkg;

  typedef enum logic [3:0] {
    OP_NONE     = 4'h0,
    OP_JUMP     = 4'h1,
    OP_JUMP_CC  = 4'h2,
    OP_CALL     = 4'h3,
    OP_JUMP_REG = 4'h4,
    OP_CALL_REG = 4'h5,
    OP_CMP_ZERO = 4'h6,
    OP_CMP_NZ   = 4'h7,
    OP_IF_THEN  = 4'h8,
    OP_TBL_BYTE = 4'h9,
    OP_TBL_HALF = 4'hA,
    OP_DBG_STOP = 4'hB,
    OP_OTHER    = 4'hC
  } op_e;

  typedef enum logic [0:0] {
    ST_IDLE  = 1'b0,
    ST_TABLE = 1'b1
  } unit_state_e;

  typedef struct packed {
    op_e         op;
    logic [3:0]  cond;
    logic [3:0]  it_mask;
    logic [31:0] disp;
    logic [3:0]  opnd_idx;
    logic [31:0] opnd_val;
    logic        rn_is_pc;
    logic [31:0] rn_val;
    logic [31:0] rm_val;
    logic [31:0] pc;
    logic        wide;
  } instr_s;

  typedef struct packed {
    logic        redirect;
    logic [31:0] target;
    logic        link_we;
    logic [31:0] link;
    logic        fault;
    logic        cond_ok;
  } branch_out_s;

  typedef struct packed {
    logic [31:0] addr;
    logic        half;
  } tbl_req_s;

endpackage

// File: rtl/it_state_unit.sv
// if-then block state: base condition and remaining slot switches
`timescale 1ns/1ps
`include "branch_cfg.svh"

module it_state_unit
  import branch_pkg::*;
(
  // clock and reset
  input  wire logic       sys_clk,
  input  wire logic       rst_n,
  input  wire logic       clk_en,
  // control
  input  wire logic       load,
  input  wire logic [7:0] load_val,
  input  wire logic       advance,
  input  wire logic       clear,
  input  wire logic       restore,
  input  wire logic [7:0] restore_val,
  // state
  output logic [7:0]      state_q,
  output logic            active,
  output logic [3:0]      slot_cond
);

  logic [7:0] state_d;

  // -----------------------------------------------------------------
  // next state
  // -----------------------------------------------------------------
  always_comb begin
    state_d = state_q;
    if (restore) begin
      state_d = restore_val;                                      // RL16
    end else if (clear) begin
      state_d = `IT_STATE_RESET;                                  // RL16
    end else if (load) begin
      state_d = load_val;                                         // RL12
    end else if (advance) begin
      // last slot leaves only the terminator: block ends
      if (state_q[2:0] == `IT_SLOT_NONE) begin
        state_d = `IT_STATE_RESET;                                // RL23
      end else begin
        state_d = {state_q[7:5], state_q[3:0], 1'b0};             // RL23
      end
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      state_q <= `IT_STATE_RESET;
    end else if (clk_en) begin
      state_q <= state_d;
    end
  end

  assign active    = (state_q[3:0] != 4'h0);
  // bit 4 carries then (base) or else (inverse) for the current slot
  assign slot_cond = state_q[7:4];                                // RL13

endmodule

// File: verification/branch_unit_chk.sv
// port-level checks for the branch unit
`timescale 1ns/1ps
module branch_unit_chk
  import branch_pkg::*;
(
  // clock and reset
  input wire logic       sys_clk,
  input wire logic       rst_n,
  input wire logic       clk_en,
  // instruction stream
  input wire logic       instr_valid,
  input instr_s          instr,
  input wire logic       instr_ready,
  input branch_out_s     result_q,
  input wire logic       it_active,
  // exceptions and table port
  input wire logic       exc_return,
  input wire logic [7:0] exc_it_restore,
  input wire logic [7:0] exc_it_save,
  input wire logic       tbl_valid,
  input tbl_req_s        tbl_q,
  input wire logic       tbl_ack,
  input wire logic [15:0] tbl_data
);
  logic        acc;
  logic        cmp_take;
  logic [31:0] disp25;
  logic [31:0] tbl_pc_q;
  logic [31:0] tbl_pc_d;
  assign acc = instr_valid && instr_ready && clk_en;
  assign cmp_take = (instr.opnd_val == 32'h0) ^ (instr.op == OP_CMP_NZ);
  assign disp25 = {{7{instr.disp[24]}}, instr.disp[24:0]};
  // table pc is kept because the target forms long after acceptance
  always_comb begin
    tbl_pc_d = tbl_pc_q;
    if (acc && (instr.op == OP_TBL_BYTE || instr.op == OP_TBL_HALF)) begin
      tbl_pc_d = instr.pc;
    end
  end
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      tbl_pc_q <= 32'h0;
    end else begin
      tbl_pc_q <= tbl_pc_d;
    end
  end
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_n);
  a_call_link_next: assert property (acc && instr.op == OP_CALL && !it_active |=> result_q.link_we &&
    result_q.link == $past(instr.pc) + ($past(instr.wide) ? 32'h4 : 32'h2)) else $error("call link wrong");
  a_imm_jump_range: assert property (acc && (instr.op == OP_JUMP || instr.op == OP_CALL) && !it_active
    |=> result_q.redirect && result_q.target == $past(instr.pc) + 32'h4 + $past(disp25)) else $error("jump target");
  a_reg_even_fault: assert property (acc && instr.op inside {OP_JUMP_REG, OP_CALL_REG} && !instr.rm_val[0]
    && !it_active |=> result_q.fault && !result_q.redirect) else $error("no fault on even target");
  a_reg_bit_clear: assert property (acc && instr.op inside {OP_JUMP_REG, OP_CALL_REG} && instr.rm_val[0]
    && !it_active |=> result_q.target == {$past(instr.rm_val[31:1]), 1'b0}) else $error("register target");
  a_cmp_zero_take: assert property (acc && instr.op inside {OP_CMP_ZERO, OP_CMP_NZ} && instr.opnd_idx <= 4'h7
    |=> result_q.redirect == $past(cmp_take)) else $error("compare jump decision");
  a_cmp_high_fault: assert property (acc && instr.op inside {OP_CMP_ZERO, OP_CMP_NZ} && instr.opnd_idx > 4'h7
    |=> result_q.fault) else $error("high register accepted");
  a_tbl_half_addr: assert property (acc && instr.op == OP_TBL_HALF |=> tbl_valid && tbl_q.half &&
    tbl_q.addr == ($past(instr.rn_is_pc) ? $past(instr.pc) + 32'h4 : $past(instr.rn_val)) + {$past(instr.rm_val[30:0]), 1'b0})
    else $error("table address");
  a_tbl_fwd_target: assert property (clk_en && tbl_valid && tbl_ack |=> result_q.redirect &&
    result_q.target == tbl_pc_q + 32'h4 +
    ($past(tbl_q.half) ? {15'h0, $past(tbl_data), 1'b0} : {23'h0, $past(tbl_data[7:0]), 1'b0}))
    else $error("table target");
  a_it_goes_active: assert property (acc && instr.op == OP_IF_THEN && !it_active |=> it_active)
    else $error("block not opened");
  a_dbg_stop_runs: assert property (acc && instr.op == OP_DBG_STOP |=> result_q.cond_ok)
    else $error("debug stop skipped");
  a_exc_restore_state: assert property (clk_en && exc_return |=> exc_it_save == $past(exc_it_restore))
    else $error("block state not restored");
endmodule

// File: verification/test_branch_unit.sv
// self-checking bench for the branch unit
`timescale 1ns/1ps
module test_branch_unit
  import branch_pkg::*;
;
  logic        sys_clk = 1'b0;
  logic        rst_n = 1'b0;
  logic        clk_en = 1'b1;
  logic        instr_valid = 1'b0;
  logic        instr_ready;
  logic        it_active;
  logic        exc_entry = 1'b0;
  logic        exc_return = 1'b0;
  logic        tbl_valid;
  logic        tbl_ack = 1'b0;
  logic [3:0]  flags_nzcv = 4'h4;
  logic [7:0]  exc_it_restore = 8'h00;
  logic [7:0]  exc_it_save;
  logic [15:0] tbl_data = 16'h0000;
  instr_s      instr = '0;
  branch_out_s result_q;
  tbl_req_s    tbl_q;
  branch_out_s r;
  int          errors = 0;
  int          cmp_count = 0;
  branch_unit u_branch_unit (
    .sys_clk(sys_clk), .rst_n(rst_n), .clk_en(clk_en), .instr_valid(instr_valid), .instr(instr),
    .instr_ready(instr_ready), .flags_nzcv(flags_nzcv), .result_q(result_q), .it_active(it_active),
    .exc_entry(exc_entry), .exc_return(exc_return), .exc_it_restore(exc_it_restore), .exc_it_save(exc_it_save),
    .tbl_valid(tbl_valid), .tbl_q(tbl_q), .tbl_ack(tbl_ack), .tbl_data(tbl_data));
  initial begin
    forever #20 sys_clk = ~sys_clk;
  end
  task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      errors++;
      $display("MISMATCH %s expected %h seen %h", name, exp, seen);
    end
  endtask
  task automatic print_verdict;
    $display("compares %0d mismatches %0d", cmp_count, errors);
    if (errors == 0 && cmp_count > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask
  function automatic instr_s mk(op_e op, logic [31:0] pc, logic [31:0] disp);
    mk = '0;
    mk.op = op;
    mk.pc = pc;
    mk.disp = disp;
    mk.wide = 1'b1;
  endfunction
  // holds the request until the edge that takes it, result read just after that edge
  task automatic send(input instr_s i);
    int n;
    n = 0;
    @(posedge sys_clk);
    instr <= i;
    instr_valid <= 1'b1;
    #1;
    while (instr_ready !== 1'b1 && n < 20) begin
      @(posedge sys_clk);
      #1;
      n++;
    end
    @(posedge sys_clk);
    instr_valid <= 1'b0;
    #1;
    r = result_q;
  endtask
  task automatic t_jumps;
    send(mk(OP_CALL, 32'h0100_0000, 32'h0100_0000));
    chk("call target", r.target, 32'h0000_0004);
    chk("call link", r.link, 32'h0100_0004);
    chk("call bits", 32'({r.redirect, r.link_we, r.fault}), 32'h6);
    send(mk(OP_JUMP_CC, 32'h0020_0000, 32'h0010_0000));
    chk("cond jump target", r.target, 32'h0010_0004);
    chk("cond jump taken", 32'(r.redirect), 32'h1);
    $display("jumps done");
  endtask
  task automatic t_regs;
    instr_s i;
    i = mk(OP_CALL_REG, 32'h0000_1000, '0);
    i.wide = 1'b0;
    i.rm_val = 32'h0000_2001;
    send(i);
    chk("reg target", r.target, 32'h0000_2000);
    chk("reg link", r.link, 32'h0000_1002);
    i.op = OP_JUMP_REG;
    i.rm_val = 32'h0000_2000;
    send(i);
    chk("reg fault", 32'({r.redirect, r.fault}), 32'h1);
    $display("register jumps done");
  endtask
  task automatic t_cmp;
    instr_s i;
    for (int k = 0; k < 4; k++) begin
      i = mk(k[0] ? OP_CMP_NZ : OP_CMP_ZERO, 32'h0000_0100, 32'h0000_007E);
      i.opnd_idx = 4'h7;
      i.opnd_val = k[1] ? 32'h0000_0005 : 32'h0;
      send(i);
      chk("cmp take", 32'(r.redirect), 32'(k[0] == k[1]));
      if (k[0] == k[1]) chk("cmp target", r.target, 32'h0000_0182);
    end
    i.opnd_idx = 4'h8;
    send(i);
    chk("cmp high reg", 32'(r.fault), 32'h1);
    $display("compare jumps done");
  endtask
  task automatic tbl_run(input instr_s i, input logic [15:0] entry, input logic [31:0] addr, input logic [31:0] tgt);
    send(i);
    chk("tbl valid", 32'(tbl_valid), 32'h1);
    chk("tbl addr", tbl_q.addr, addr);
    chk("tbl half", 32'(tbl_q.half), 32'(i.op == OP_TBL_HALF));
    chk("tbl refuses", 32'(instr_ready), 32'h0);
    @(posedge sys_clk);
    tbl_ack <= 1'b1;
    tbl_data <= entry;
    @(posedge sys_clk);
    tbl_ack <= 1'b0;
    tbl_data <= ~entry;
    #1;
    chk("tbl target", result_q.target, tgt);
  endtask
  task automatic t_table;
    instr_s i;
    i = mk(OP_TBL_BYTE, 32'h0000_0400, '0);
    i.rn_is_pc = 1'b1;
    i.rm_val = 32'h3;
    tbl_run(i, 16'hFF81, 32'h0000_0407, 32'h0000_0506);
    i.op = OP_TBL_HALF;
    i.rn_is_pc = 1'b0;
    i.rn_val = 32'h0000_0800;
    tbl_run(i, 16'h8001, 32'h0000_0806, 32'h0001_0406);
    $display("table jumps done");
  endtask
  task automatic t_it;
    instr_s i;
    i = mk(OP_IF_THEN, 32'h0000_0200, '0);
    i.it_mask = 4'hE;
    send(i);
    chk("it active", 32'(it_active), 32'h1);
    chk("it state", 32'(exc_it_save), 32'h0E);
    send(mk(OP_OTHER, 32'h0000_0202, '0));
    chk("then slot", 32'(r.cond_ok), 32'h1);
    send(mk(OP_OTHER, 32'h0000_0204, '0));
    chk("else slot", 32'(r.cond_ok), 32'h0);
    send(mk(OP_DBG_STOP, 32'h0000_0206, '0));
    chk("stop in else", 32'(r.cond_ok), 32'h1);
    chk("it closed", 32'(it_active), 32'h0);
    $display("if-then done");
  endtask
  task automatic t_exc;
    instr_s i;
    i = mk(OP_IF_THEN, 32'h0000_0300, '0);
    i.it_mask = 4'h4;
    send(i);
    @(posedge sys_clk);
    exc_entry <= 1'b1;
    flags_nzcv <= 4'h0;
    #1;
    chk("exc refuses", 32'(instr_ready), 32'h0);
    @(posedge sys_clk);
    exc_entry <= 1'b0;
    #1;
    chk("exc clears", 32'(it_active), 32'h0);
    @(posedge sys_clk);
    exc_return <= 1'b1;
    exc_it_restore <= 8'h04;
    @(posedge sys_clk);
    exc_return <= 1'b0;
    exc_it_restore <= 8'hFB;
    #1;
    chk("exc restore", 32'(exc_it_save), 32'h04);
    send(mk(OP_OTHER, 32'h0000_0302, '0));
    chk("resumed slot", 32'(r.cond_ok), 32'h0);
    send(mk(OP_OTHER, 32'h0000_0304, '0));
    chk("two slot end", 32'(it_active), 32'h0);
    $display("exception resume done");
  endtask
  // a frozen unit must neither drop its pulse nor take the offered prefix
  task automatic t_hold;
    instr_s i;
    @(posedge sys_clk);
    instr <= mk(OP_JUMP, 32'h0000_1000, 32'h0000_0010);
    instr_valid <= 1'b1;
    @(posedge sys_clk);
    i = mk(OP_IF_THEN, 32'h0000_1004, '0);
    i.cond = 4'hE;
    i.it_mask = 4'h8;
    instr <= i;
    clk_en <= 1'b0;
    repeat (2) @(posedge sys_clk);
    instr_valid <= 1'b0;
    clk_en <= 1'b1;
    #1;
    chk("held target", result_q.target, 32'h0000_1014);
    chk("frozen block", 32'(it_active), 32'h0);
    send(i);
    send(mk(OP_OTHER, 32'h0000_1006, '0));
    chk("always slot", 32'(r.cond_ok), 32'h1);
    chk("one slot end", 32'(it_active), 32'h0);
    $display("clock enable and always block done");
  endtask
  // under a hundred cycles are needed; ten thousand means a hang
  initial begin
    #400000;
    errors++;
    print_verdict;
  end
  initial begin
    repeat (6) @(posedge sys_clk);
    rst_n <= 1'b1;
    t_jumps;
    t_regs;
    t_cmp;
    t_table;
    t_it;
    t_exc;
    t_hold;
    print_verdict;
  end
endmodule
bind branch_unit branch_unit_chk u_branch_unit_chk (
  .sys_clk(sys_clk), .rst_n(rst_n), .clk_en(clk_en), .instr_valid(instr_valid), .instr(instr),
  .instr_ready(instr_ready), .result_q(result_q), .it_active(it_active), .exc_return(exc_return),
  .exc_it_restore(exc_it_restore), .exc_it_save(exc_it_save), .tbl_valid(tbl_valid), .tbl_q(tbl_q),
  .tbl_ack(tbl_ack), .tbl_data(tbl_data));
